// file: include/aef_map.svh
// Register offsets, field positions and reset values for the alert and event flag logic.
// Assumes an internal register port with byte-wide data and 8-bit register addresses.
// Functional notes
// (R1) Scan channel enable bit set includes that input in the automatic scan.
// (R2) Alert channel enable bit lets that channel's flags drive the alert pin.
// (R3) With CRC alert enable set, input CRC error flag asserts the alert pin.
// (R4) Host must clear the input CRC error flag to release a CRC alert.
// (R5) Alert setup bit 2 selects drive: 0 open-drain, 1 push-pull.
// (R6) Signalling code 00 pulses once per alert flag; 01 holds level while alert.
// (R7) Read-only eight-bit event summary, one bit per channel.
// (R8) Summary bits clear only by clearing the channel's high and low flags.
// (R9) High flag sets on conversion above high threshold or digital input one.
// (R10) Writing one to a high flag bit clears it; zero leaves it.
// (R11) Reserved bits of source map and pin setup read zero, ignore writes.
// (R12) Scan go in automatic mode converts enabled channels ascending; clearing stops.
// (R13) Low flag sets past low threshold or digital zero; writing one clears.
// (R14) Summary bit is OR of high and low flags, one cycle later.
// (R15) Signalling codes 10 and 11 behave as the active-high level setting.
`ifndef AEF_MAP_SVH
`define AEF_MAP_SVH
`define AEF_OFS_SEQ_CFG 8'h10
`define AEF_OFS_SCAN_MASK 8'h12
`define AEF_OFS_ALERT_MASK 8'h14
`define AEF_OFS_SRC_MAP 8'h16
`define AEF_OFS_PIN_SETUP 8'h17
`define AEF_OFS_SUMMARY 8'h18
`define AEF_OFS_HIGH_FLAGS 8'h1a
`define AEF_OFS_LOW_FLAGS 8'h1c
`define AEF_BIT_CRC_EN 0
`define AEF_BIT_DRIVE 2
`define AEF_BIT_SCAN_GO 4
`define AEF_MSK_SRC_MAP 8'h01
`define AEF_MSK_PIN_SETUP 8'h07
`define AEF_MSK_SEQ_CFG 8'h13
`define AEF_RST_REG 8'h00
`define AEF_STYLE_AUTO 2'h1
`define AEF_SIG_PULSE 2'h0
`endif

// file: include/aef_pkg.sv
// Types shared by the alert and event flag logic.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package aef_pkg;
    typedef struct packed {
        logic [7:0] above;
        logic [7:0] below;
    } aef_event_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } aef_req_t;
    typedef enum logic [2:0] {
        AEF_SCAN_IDLE = 3'b001,
        AEF_SCAN_RUN = 3'b010,
        AEF_SCAN_WRAP = 3'b100
    } aef_scan_t;
endpackage : aef_pkg
`default_nettype wire

// file: hw/aef_scan_seq.sv
// Automatic scan channel picker: walks enabled channels in ascending order.
// Assumes i_next is a one-cycle pulse from the converter when a conversion ends.
`default_nettype none
module aef_scan_seq (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_run,
    input wire logic [7:0] i_mask,
    input wire logic i_next,
    output logic o_active,
    output logic [2:0] o_chan
);
    aef_pkg::aef_scan_t state_r;
    aef_pkg::aef_scan_t state_nxt;
    logic [2:0] chan_r;
    logic [2:0] chan_nxt;
    logic [2:0] first;
    logic [2:0] after;
    logic has_after;
    logic [3:0] k;

    always_comb begin
        first = 3'h0;
        after = 3'h0;
        has_after = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            if (i_mask[i]) begin
                first = 3'(i);
            end
            k = 4'(i);
            if (i_mask[i] && k > {1'b0, chan_r}) begin
                after = 3'(i);
                has_after = 1'b1;
            end
        end
    end

    always_comb begin
        state_nxt = state_r;
        chan_nxt = chan_r;
        case (state_r)
            aef_pkg::AEF_SCAN_IDLE: begin
                if (i_run && i_mask != 8'h00) begin
                    state_nxt = aef_pkg::AEF_SCAN_RUN;
                    chan_nxt = first; // see (R12)
                end
            end
            aef_pkg::AEF_SCAN_RUN: begin
                if (!i_run || i_mask == 8'h00) begin
                    state_nxt = aef_pkg::AEF_SCAN_IDLE; // see (R12)
                end else if (i_next) begin
                    if (has_after) begin
                        chan_nxt = after; // see (R1)
                    end else begin
                        state_nxt = aef_pkg::AEF_SCAN_WRAP;
                    end
                end
            end
            aef_pkg::AEF_SCAN_WRAP: begin
                state_nxt = aef_pkg::AEF_SCAN_RUN;
                chan_nxt = first;
                if (!i_run || i_mask == 8'h00) begin
                    state_nxt = aef_pkg::AEF_SCAN_IDLE;
                end
            end
            default: begin
                state_nxt = aef_pkg::AEF_SCAN_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_r <= aef_pkg::AEF_SCAN_IDLE;
            chan_r <= 3'h0;
        end else begin
            state_r <= state_nxt;
            chan_r <= chan_nxt;
        end
    end

    assign o_active = (state_r == aef_pkg::AEF_SCAN_RUN);
    assign o_chan = chan_r;
endmodule : aef_scan_seq
`default_nettype wire

// file: hw/aef_alert_flags.sv
// Alert and event flag block: channel flags, summary, alert pin and scan mask registers.
// Assumes register requests and event strobes come from logic on the same clock.
// The alert pin drives a two-way pad; the pad cell resolves the wire level.
`include "aef_map.svh"
`default_nettype none
module aef_alert_flags (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire aef_pkg::aef_req_t i_req,
    output logic [7:0] o_rdata,
    input wire aef_pkg::aef_event_t i_cmp,
    input wire logic [7:0] i_digital_sel,
    input wire logic [7:0] i_digital_in,
    input wire logic i_input_crc_error_flag,
    input wire logic i_conv_done,
    output logic o_scan_active,
    output logic [2:0] o_scan_chan,
    output logic o_alert_out,
    output logic o_alert_oe
);
    ////////////////////////////////////////////////////////////////////////////////
    logic [7:0] scan_channel_mask_r, scan_channel_mask_nxt;
    logic [7:0] alert_channel_mask_r, alert_channel_mask_nxt;
    logic crc_input_alert_enable_r, crc_input_alert_enable_nxt;
    logic [2:0] pin_setup_r, pin_setup_nxt;
    logic [4:0] seq_cfg_r, seq_cfg_nxt;
    logic [7:0] high_r, high_nxt;
    logic [7:0] low_r, low_nxt;
    logic [7:0] summary_r, summary_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic alert_r, alert_nxt;
    logic [7:0] dig_s1_r, dig_s2_r;
    logic [7:0] dig_hi, dig_lo, set_hi, set_lo, clr_hi, clr_lo;
    logic [7:0] chan_alert, chan_alert_q_r, new_flag;
    logic crc_alert, crc_alert_q_r, alert_level, pulse_mode;
    logic [1:0] scan_style;
    logic scan_go;

    // Digital pin levels come from pads, so they pass two flip-flops first.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            dig_s1_r <= 8'h00;
            dig_s2_r <= 8'h00;
        end else begin
            dig_s1_r <= i_digital_in;
            dig_s2_r <= dig_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-channel flag set and clear terms.
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_chan
            assign dig_hi[g] = i_digital_sel[g] & dig_s2_r[g];
            assign dig_lo[g] = i_digital_sel[g] & ~dig_s2_r[g];
            assign set_hi[g] = (~i_digital_sel[g] & i_cmp.above[g]) | dig_hi[g]; // see (R9)
            assign set_lo[g] = (~i_digital_sel[g] & i_cmp.below[g]) | dig_lo[g]; // see (R13)
            assign chan_alert[g] = alert_channel_mask_r[g] & (high_r[g] | low_r[g]); // see (R2)
        end
    endgenerate

    always_comb begin
        clr_hi = 8'h00;
        clr_lo = 8'h00;
        if (i_req.wr && i_req.addr == `AEF_OFS_HIGH_FLAGS) begin
            clr_hi = i_req.wdata; // see (R10)
        end else if (i_req.wr && i_req.addr == `AEF_OFS_LOW_FLAGS) begin
            clr_lo = i_req.wdata; // see (R13)
        end
        // A set in the same cycle as its clear wins, so no event is lost.
        high_nxt = (high_r & ~clr_hi) | set_hi;
        low_nxt = (low_r & ~clr_lo) | set_lo;
        summary_nxt = high_r | low_r; // see (R7) (R8) (R14)
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration registers; reserved bits are never stored.
    always_comb begin
        scan_channel_mask_nxt = scan_channel_mask_r;
        alert_channel_mask_nxt = alert_channel_mask_r;
        crc_input_alert_enable_nxt = crc_input_alert_enable_r;
        pin_setup_nxt = pin_setup_r;
        seq_cfg_nxt = seq_cfg_r;
        if (i_req.wr) begin
            if (i_req.addr == `AEF_OFS_SCAN_MASK) begin
                scan_channel_mask_nxt = i_req.wdata; // see (R1)
            end else if (i_req.addr == `AEF_OFS_ALERT_MASK) begin
                alert_channel_mask_nxt = i_req.wdata;
            end else if (i_req.addr == `AEF_OFS_SRC_MAP) begin
                crc_input_alert_enable_nxt = i_req.wdata[`AEF_BIT_CRC_EN]; // see (R11)
            end else if (i_req.addr == `AEF_OFS_PIN_SETUP) begin
                pin_setup_nxt = i_req.wdata[2:0]; // see (R11)
            end else if (i_req.addr == `AEF_OFS_SEQ_CFG) begin
                seq_cfg_nxt = 5'(i_req.wdata & `AEF_MSK_SEQ_CFG);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped addresses and reserved bits read zero.
    always_comb begin
        rdata_nxt = rdata_r;
        if (i_req.rd) begin
            if (i_req.addr == `AEF_OFS_SCAN_MASK) begin
                rdata_nxt = scan_channel_mask_r;
            end else if (i_req.addr == `AEF_OFS_ALERT_MASK) begin
                rdata_nxt = alert_channel_mask_r;
            end else if (i_req.addr == `AEF_OFS_SRC_MAP) begin
                rdata_nxt = {7'h00, crc_input_alert_enable_r}; // see (R11)
            end else if (i_req.addr == `AEF_OFS_PIN_SETUP) begin
                rdata_nxt = {5'h00, pin_setup_r}; // see (R11)
            end else if (i_req.addr == `AEF_OFS_SUMMARY) begin
                rdata_nxt = summary_r; // see (R7)
            end else if (i_req.addr == `AEF_OFS_HIGH_FLAGS) begin
                rdata_nxt = high_r;
            end else if (i_req.addr == `AEF_OFS_LOW_FLAGS) begin
                rdata_nxt = low_r;
            end else if (i_req.addr == `AEF_OFS_SEQ_CFG) begin
                rdata_nxt = {3'h0, seq_cfg_r};
            end else begin
                rdata_nxt = 8'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Alert pin. The CRC term stays until the host clears the error flag upstream.
    assign crc_alert = crc_input_alert_enable_r & i_input_crc_error_flag; // see (R3) (R4)
    assign alert_level = (|chan_alert) | crc_alert;
    assign new_flag = chan_alert & ~chan_alert_q_r;
    // Codes 10 and 11 fall through to the level behaviour.
    assign pulse_mode = (pin_setup_r[1:0] == `AEF_SIG_PULSE); // see (R15)

    always_comb begin
        if (pulse_mode) begin
            alert_nxt = (|new_flag) | (crc_alert & ~crc_alert_q_r); // see (R6)
        end else begin
            alert_nxt = alert_level; // see (R6) (R15)
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            scan_channel_mask_r <= `AEF_RST_REG;
            alert_channel_mask_r <= `AEF_RST_REG;
            crc_input_alert_enable_r <= 1'b0;
            pin_setup_r <= 3'h0;
            seq_cfg_r <= 5'h00;
            high_r <= `AEF_RST_REG;
            low_r <= `AEF_RST_REG;
            summary_r <= `AEF_RST_REG;
            rdata_r <= `AEF_RST_REG;
            alert_r <= 1'b0;
            chan_alert_q_r <= 8'h00;
            crc_alert_q_r <= 1'b0;
        end else begin
            scan_channel_mask_r <= scan_channel_mask_nxt;
            alert_channel_mask_r <= alert_channel_mask_nxt;
            crc_input_alert_enable_r <= crc_input_alert_enable_nxt;
            pin_setup_r <= pin_setup_nxt;
            seq_cfg_r <= seq_cfg_nxt;
            high_r <= high_nxt;
            low_r <= low_nxt;
            summary_r <= summary_nxt;
            rdata_r <= rdata_nxt;
            alert_r <= alert_nxt;
            chan_alert_q_r <= chan_alert;
            crc_alert_q_r <= crc_alert;
        end
    end

    // Open-drain only ever drives low; active-high alert means release when open-drain.
    assign o_alert_out = pin_setup_r[`AEF_BIT_DRIVE] ? alert_r : 1'b0; // see (R5)
    assign o_alert_oe = pin_setup_r[`AEF_BIT_DRIVE] ? 1'b1 : ~alert_r; // see (R5)
    assign o_rdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////////////
    assign scan_style = seq_cfg_r[1:0];
    assign scan_go = seq_cfg_r[`AEF_BIT_SCAN_GO];

    aef_scan_seq u_scan (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_run(scan_go && scan_style == `AEF_STYLE_AUTO), // see (R12)
        .i_mask(scan_channel_mask_r),
        .i_next(i_conv_done),
        .o_active(o_scan_active),
        .o_chan(o_scan_chan)
    );
endmodule : aef_alert_flags
`default_nettype wire

// file: sim/aef_host.sv
// Host model: register access task and the resolved alert wire.
// Assumes the bench calls acc; requests change at falling edges.
`default_nettype none
module aef_host (
    input wire logic i_clk,
    output var aef_pkg::aef_req_t o_req,
    input wire logic [7:0] i_rdata,
    input wire logic i_alert_out,
    input wire logic i_alert_oe,
    output logic o_alert_wire
);
    timeunit 1ns;
    timeprecision 1ps;
    // A released pad floats up to the board pull-up.
    assign o_alert_wire = i_alert_oe ? i_alert_out : 1'b1;
    initial o_req = '0;
    // The idle bus shows inverted values so stale data cannot pass for fresh.
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        @(negedge i_clk);
        o_req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge i_clk);
        o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        @(negedge i_clk);
        q = i_rdata;
    endtask : acc
endmodule : aef_host
`default_nettype wire

// file: sim/aef_alert_flags_chk.sv
// Port checker for the alert and event flag block.
// Assumes a bind to aef_alert_flags; it sees that module's ports only.
`include "aef_map.svh"
`default_nettype none
module aef_alert_flags_chk (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire aef_pkg::aef_req_t i_req,
    input wire logic [7:0] o_rdata,
    input wire aef_pkg::aef_event_t i_cmp,
    input wire logic [7:0] i_digital_sel,
    input wire logic i_input_crc_error_flag,
    input wire logic o_alert_out,
    input wire logic o_alert_oe
);
    // Settings are shadowed from writes; quiet_r waits out pipeline lag after a write.
    logic [7:0] pin_r, map_r, msk_r;
    logic [2:0] quiet_r;
    logic [26:0] sh_nxt;
    logic calm, asrt;
    always_comb begin
        sh_nxt = {pin_r, map_r, msk_r, quiet_r + {2'h0, quiet_r != 3'h7}};
        if (i_req.wr) begin
            sh_nxt[2:0] = 3'h0;
            case (i_req.addr)
                `AEF_OFS_PIN_SETUP: sh_nxt[26:19] = i_req.wdata & `AEF_MSK_PIN_SETUP;
                `AEF_OFS_SRC_MAP: sh_nxt[18:11] = i_req.wdata & `AEF_MSK_SRC_MAP;
                `AEF_OFS_ALERT_MASK: sh_nxt[10:3] = i_req.wdata;
                default: ;
            endcase
        end
        calm = quiet_r > 3'h3;
        asrt = pin_r[`AEF_BIT_DRIVE] ? o_alert_out : !o_alert_oe;
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) {pin_r, map_r, msk_r, quiet_r} <= '0;
        else {pin_r, map_r, msk_r, quiet_r} <= sh_nxt;
    end
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    drive_pp_a: assert property (calm && pin_r[2] |-> o_alert_oe)
        else $error("push-pull pad released");
    od_low_a: assert property (calm && !pin_r[2] |-> !o_alert_out)
        else $error("open-drain pad driven high");
    src_mute_a: assert property (calm && msk_r == 8'h00 && !map_r[0] |-> !asrt)
        else $error("alert with no source enabled");
    crc_alert_a: assert property (calm && map_r[0] && pin_r[1:0] != 2'h0
        && $past(i_input_crc_error_flag, 2) && $past(i_input_crc_error_flag)
        && i_input_crc_error_flag |-> asrt) else $error("crc alert missing");
    chan_level_a: assert property (calm && pin_r[1:0] != 2'h0
        && ($past(i_cmp.above, 3) & msk_r) != 8'h00 |-> asrt) else $error("flag not on pin");
    pulse_one_a: assert property (calm && pin_r == 8'h04 && $rose(o_alert_out)
        && $past(i_cmp) == '0 && !$past(i_input_crc_error_flag) && i_digital_sel == 8'h00
        |=> !o_alert_out) else $error("alert pulse too long");
    res_map_a: assert property ($past(i_req.rd, 2) && !$past(i_req.rd)
        && $past(i_req.addr, 2) == `AEF_OFS_SRC_MAP |-> o_rdata[7:1] == 7'h00)
        else $error("reserved map bits set");
    res_pin_a: assert property ($past(i_req.rd, 2) && !$past(i_req.rd)
        && $past(i_req.addr, 2) == `AEF_OFS_PIN_SETUP |-> o_rdata[7:3] == 5'h00)
        else $error("reserved setup bits set");
    cover property (calm && pin_r[1:0] == 2'h0 && $rose(o_alert_out));
    cover property (calm && map_r[0] && i_input_crc_error_flag && asrt);
    cover property (calm && !pin_r[2] && !o_alert_oe);
endmodule : aef_alert_flags_chk
`default_nettype wire

// file: sim/aef_alert_flags_bench.sv
// Bench for the alert and event flag block: a register table, then hand cases.
// Assumes the host model and the port checker are compiled before it.
`default_nettype none
module aef_alert_flags_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'b0, i_rst = 1'b1, crc = 1'b0, done = 1'b0;
    logic act, aout, aoe, pin;
    logic [2:0] chan;
    logic [7:0] rdata, v, n, dsel = 8'h00, din = 8'h00;
    aef_pkg::aef_req_t req;
    aef_pkg::aef_event_t cmp = '0;
    int n_mismatch = 0, num_checks = 0;
    // Rows: address, written value, value read back.
    logic [23:0] rows [9] = '{24'h12ffff, 24'h14a5a5, 24'h16ff01, 24'h17ff07,
                              24'h18ff00, 24'h1aff00, 24'h1cff00, 24'h11ff00, 24'h10ff13};
    always #10 i_clk = ~i_clk;
    aef_host i_host (.i_clk(i_clk), .o_req(req), .i_rdata(rdata), .i_alert_out(aout),
        .i_alert_oe(aoe), .o_alert_wire(pin));
    aef_alert_flags i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_req(req), .o_rdata(rdata),
        .i_cmp(cmp), .i_digital_sel(dsel), .i_digital_in(din), .i_input_crc_error_flag(crc),
        .i_conv_done(done), .o_scan_active(act), .o_scan_chan(chan), .o_alert_out(aout),
        .o_alert_oe(aoe));
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
        end
    endtask : chk
    task automatic tk(input int c);
        repeat (c) @(negedge i_clk);
    endtask : tk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_host.acc(1'b1, a, d, v);
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        i_host.acc(1'b0, a, 8'h00, v);
        chk(v, e);
    endtask : rc
    task automatic pc(input logic e);
        tk(3);
        chk({7'h00, pin}, {7'h00, e});
    endtask : pc
    task automatic ev(input logic [7:0] hi, input logic [7:0] lo);
        cmp = '{above: hi, below: lo};
        tk(1);
        cmp = '0;
    endtask : ev
    task automatic stop_test;
        $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test
    ////////////////////////////////////////////////////////////
    initial begin
        tk(16);
        i_rst = 1'b0;
        foreach (rows[i]) begin
            rc(rows[i][23:16], 8'h00);
            wr(rows[i][23:16], rows[i][15:8]);
            rc(rows[i][23:16], rows[i][7:0]);
        end
        // The last row leaves go set with a non-automatic style, so no scan may run.
        chk({7'h00, act}, 8'h00);
        $display("register table done");
        // A reset after the table must drop the settings the table left behind; only the source map is read back.
        i_rst = 1'b1;
        tk(2);
        i_rst = 1'b0;
        rc(8'h16, 8'h00);
        ev(8'h81, 8'h02);
        tk(2);
        rc(8'h1a, 8'h81);
        rc(8'h1c, 8'h02);
        rc(8'h18, 8'h83);
        wr(8'h1a, 8'h01);
        wr(8'h1a, 8'h00);
        rc(8'h1a, 8'h80);
        wr(8'h1c, 8'h02);
        rc(8'h18, 8'h80);
        $display("flag test done");
        wr(8'h17, 8'h05);
        wr(8'h14, 8'h80);
        ev(8'h80, 8'h00);
        pc(1'b1);
        wr(8'h1a, 8'h80);
        pc(1'b0);
        wr(8'h14, 8'h01);
        ev(8'h80, 8'h00);
        pc(1'b0);
        wr(8'h16, 8'h01);
        crc = 1'b1;
        pc(1'b1);
        wr(8'h17, 8'h01);
        tk(3);
        chk({6'h00, aoe, pin}, 8'h01);
        crc = 1'b0;
        tk(3);
        chk({5'h00, aoe, aout, pin}, 8'h04);
        wr(8'h16, 8'h00);
        crc = 1'b1;
        pc(1'b0);
        crc = 1'b0;
        $display("alert pin test done");
        wr(8'h17, 8'h04);
        tk(4);
        ev(8'h01, 8'h00);
        n = 8'h00;
        repeat (8) begin
            tk(1);
            n = n + {7'h00, pin};
        end
        chk(n, 8'h01);
        for (int c = 6; c < 8; c++) begin
            wr(8'h17, c[7:0]);
            pc(1'b1);
        end
        din = 8'h04;
        tk(4);
        dsel = 8'h04;
        tk(4);
        din = 8'h00;
        tk(5);
        rc(8'h1a, 8'h85);
        rc(8'h1c, 8'h04);
        $display("pulse and digital test done");
        wr(8'h12, 8'h0a);
        wr(8'h10, 8'h11);
        tk(2);
        chk({act, 4'h0, chan}, 8'h81);
        for (int k = 0; k < 2; k++) begin
            done = 1'b1;
            tk(1);
            done = 1'b0;
            tk(3);
            chk({5'h00, chan}, k == 0 ? 8'h03 : 8'h01);
        end
        wr(8'h10, 8'h00);
        tk(2);
        chk({7'h00, act}, 8'h00);
        $display("scan test done");
        stop_test();
    end
endmodule : aef_alert_flags_bench
bind aef_alert_flags aef_alert_flags_chk i_chk (.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req),
    .o_rdata(o_rdata), .i_cmp(i_cmp), .i_digital_sel(i_digital_sel),
    .i_input_crc_error_flag(i_input_crc_error_flag), .o_alert_out(o_alert_out),
    .o_alert_oe(o_alert_oe));
`default_nettype wire
